// [hdl/gtm_timer.sv]
// Top of the 16-bit general timer with Wishbone slave and interrupt
`timescale 1ns/1ps
`default_nettype none

// Operation in brief
// Internal: one tick per mclk while on.
// Gated: internal ticks while pin high.
// Sync: pin edges after two flops.
// Async: pin edges one edge after pin.
// All ticks pass the prescaler.
// Count wraps to zero at the period,
// and that tick sets the match flag.
//
// Power states
// Idle with idle-stop freezes all modes.
// Sleep freezes all but async external.
// Both are levels from the core.
// A frozen timer keeps its prescaler.
//
// Clock enable
// With ce low nothing moves and no bus
// request is taken; ack stays low.
// Pin flops freeze too, so an edge in a
// frozen span can be lost.
//
// Prescaler
// Cleared by a count write and in the
// cycle after the enable bit falls.
// A ratio change while running is not
// aligned to a prescaler boundary;
// disable first for a clean period.
//
// Bus
// Ack comes one cycle after the take,
// and a write lands at the take edge.
// Unmapped offsets read zero.
// Lanes 0/1 carry 16-bit registers,
// lane 2 the mask beside the status.
//
// Interrupt
// irq is a flop fed by status and mask,
// so it trails both by one cycle.
// Only software clears the flags.

// Functional notes
// (RULE1) Internal mode counts cycles, wraps at period
// (RULE2) Idle halts sync modes when idle-stop set
// (RULE3) Sync counter counts synchronised external rising edges
// (RULE4) Async counter counts raw external rising edges
// (RULE5) Async counter stops in Idle if idle-stop
// (RULE6) Gated mode counts cycles while gate high
// (RULE7) Prescaler divides selected clock by 1/8/64/256
// (RULE8) Prescaler cleared: count write, disable, reset
// (RULE9) Disabled timer halts the prescaler clock
// (RULE10) Control write never alters the count
// (RULE11) Sleep counting only enabled, external, async
// (RULE12) Period match sets flag, irq if enabled
// (RULE13) Software clears the flag, hardware never does
// (RULE14) Gated mode flags gate falling edge
// (RULE15) RTC: low-power oscillator, prescaler, interrupts
// (RULE16) RTC counts oscillator rising edges to period
// (RULE17) Prescale codes 00/01/10/11 = 1/8/64/256
// (RULE18) Source select 0 internal, 1 external pin
module gtm_timer (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic gate_clock_pin,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);
    import gtm_pkg::*;

    // Software-visible state
    logic [15:0] timer_control; // Mode and enable bits
    logic [15:0] count_value; // Running count
    logic [15:0] period_value; // Match value
    logic [GTM_NUM_EV-1:0] status; // Sticky event flags
    logic [GTM_NUM_EV-1:0] irq_mask; // Event enables

    // Control fields
    logic timer_on;
    logic idle_stop;
    logic gate_accumulate_enable;
    logic external_sync_select;
    logic clock_source_select;
    gtm_ps_e prescale_select;

    assign timer_on = timer_control[GTM_BIT_ON];
    assign idle_stop = timer_control[GTM_BIT_IDLE_STOP];
    assign gate_accumulate_enable = timer_control[GTM_BIT_GATE];
    assign external_sync_select = timer_control[GTM_BIT_SYNC];
    assign clock_source_select = timer_control[GTM_BIT_SRC];
    assign prescale_select = gtm_ps_e'(timer_control[GTM_BIT_PS_HI:GTM_BIT_PS_LO]);

    // Bus decode
    logic bus_req; // Live request not yet answered
    logic wr_stb; // One-cycle write strobe
    logic wr_lo; // Low byte lane of the low half-word
    logic wr_hi; // High byte lane of the low half-word

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = ce && bus_req && wb_we_i;
    assign wr_lo = wb_sel_i[0];
    assign wr_hi = wb_sel_i[1];

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [31:0] d,
                                               input logic lo,
                                               input logic hi);
        lane_merge = {hi ? d[15:8] : old_v[15:8], lo ? d[7:0] : old_v[7:0]};
    endfunction

    // Register selected by the address
    function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
        hit = (adr == ofs);
    endfunction

    logic wr_control;
    logic wr_count;
    logic wr_period;
    logic wr_status;
    logic wr_mask;

    // Mask register shares the offset of the status register
    localparam logic [3:0] GTM_OFS_MASK_LOCAL = GTM_OFS_STATUS;

    assign wr_control = wr_stb && hit(wb_adr_i, GTM_OFS_CONTROL);
    assign wr_count = wr_stb && hit(wb_adr_i, GTM_OFS_COUNT) && (wr_lo || wr_hi);
    assign wr_period = wr_stb && hit(wb_adr_i, GTM_OFS_PERIOD);
    assign wr_status = wr_stb && hit(wb_adr_i, GTM_OFS_STATUS) && wr_lo;
    // Mask lives in bits 17:16 of the status word, enabled by lane 2
    assign wr_mask = wr_stb && hit(wb_adr_i, GTM_OFS_MASK_LOCAL) && wb_sel_i[2];

    // Pin edges
    logic pin_level;
    logic pin_rise_s;
    logic pin_fall_s;
    logic pin_rise_a;

    gtm_edge u_edge (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .pin(gate_clock_pin),
        .sync_level(pin_level),
        .sync_rise(pin_rise_s),
        .sync_fall(pin_fall_s),
        .raw_rise(pin_rise_a)
    );

    // Input tick selection, before the prescaler
    logic async_mode; // External source without synchronisation
    logic run_ok; // Counting allowed in the present CPU state
    logic tick_in; // Raw input tick
    logic tick_ps; // Tick after division
    logic ps_clear; // Prescaler clear request

    assign async_mode = clock_source_select && !external_sync_select;

    // Idle stops every mode when idle-stop is set; Sleep stops all but async
    always_comb begin
        run_ok = timer_on;
        if (cpu_sleep && !async_mode) begin
            run_ok = 1'b0; // see (RULE11)
        end
        if (cpu_idle && idle_stop) begin
            run_ok = 1'b0; // see (RULE2) (RULE5)
        end
    end

    // Source choice: 0 internal cycle, 1 external pin
    always_comb begin
        if (!clock_source_select) begin // see (RULE18)
            // Gated accumulation counts cycles only while the gate is high
            tick_in = gate_accumulate_enable ? pin_level : 1'b1; // see (RULE1) (RULE6)
        end else if (external_sync_select) begin
            tick_in = pin_rise_s; // see (RULE3)
        end else begin
            // Also the RTC path from the low-power oscillator
            tick_in = pin_rise_a; // see (RULE4) (RULE15) (RULE16)
        end
    end

    // Disable edge clears the prescaler, as does a count write
    logic on_d;
    always_ff @(posedge mclk) begin
        if (srst) begin
            on_d <= 1'b0;
        end else if (ce) begin
            on_d <= timer_on;
        end
    end
    assign ps_clear = wr_count || (on_d && !timer_on); // see (RULE8)

    gtm_prescale u_ps (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .run(run_ok),
        .clear(ps_clear),
        .tick_in(tick_in),
        .sel(prescale_select),
        .tick_out(tick_ps)
    );

    // Period match event on a counting tick at the period value
    logic match_ev;
    logic gate_ev;
    assign match_ev = tick_ps && (count_value == period_value) && !wr_count; // see (RULE12)
    assign gate_ev = ce && timer_on && gate_accumulate_enable && !clock_source_select
                     && pin_fall_s; // see (RULE14)

    // Control register; its writes never touch the count
    always_ff @(posedge mclk) begin
        if (srst) begin
            timer_control <= GTM_CONTROL_RST;
        end else if (wr_control) begin
            timer_control <= lane_merge(timer_control, wb_dat_i, wr_lo, wr_hi)
                             & GTM_CONTROL_MASK; // see (RULE10)
        end
    end

    // Period register
    always_ff @(posedge mclk) begin
        if (srst) begin
            period_value <= GTM_PERIOD_RST;
        end else if (wr_period) begin
            period_value <= lane_merge(period_value, wb_dat_i, wr_lo, wr_hi);
        end
    end

    // Priority: reset, software write, then a tick.
    // A tick at the period wraps, any other adds one.
    // The write strobe already carries ce, so only
    // the tick branch needs it here.
    // Count register: software write wins, else advance or wrap
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_value <= GTM_COUNT_RST;
        end else if (wr_count) begin
            count_value <= lane_merge(count_value, wb_dat_i, wr_lo, wr_hi); // see (RULE10)
        end else if (ce && tick_ps) begin
            if (count_value == period_value) begin
                count_value <= 16'h0000; // see (RULE1) (RULE3) (RULE4)
            end else begin
                count_value <= count_value + 16'h0001; // see (RULE1)
            end
        end
    end

    // Clear bits come from the low lane of the data;
    // the event OR after the clear lets the set win.
    // Sticky status: write one clears, a same-cycle event wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            status <= '0;
        end else if (ce) begin
            status <= (status & ~(wr_status ? wb_dat_i[GTM_NUM_EV-1:0] : '0))
                      | {gate_ev, match_ev}; // see (RULE12) (RULE13) (RULE14)
        end
    end

    // Interrupt mask
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= wb_dat_i[16+GTM_NUM_EV-1:16];
        end
    end

    // A flop, not a gate, so the pin cannot glitch
    // when status and mask change in one cycle.
    // Level interrupt from a flop, one cycle behind the status
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(status & irq_mask); // see (RULE12) (RULE15)
        end
    end

    // Register map, byte offsets:
    // 0 control, writable bits only:
    //   15 on, 13 idle-stop, 6 gate,
    //   5:4 prescale, 2 sync, 1 source.
    // 4 count; writes clear the prescaler.
    // 8 period, compared on each tick.
    // C status 1:0, write one to clear,
    //   mask 17:16 through lane 2.
    //
    // Hazards:
    // A period below the live count lets
    // it run through 16'hFFFF and zero.
    // A count write beats a same-cycle
    // tick, which then sets no flag.
    // Period zero sets the flag each tick.
    // The gate flag needs gate mode, the
    // internal source and the enable.
    //
    // Limitations:
    // No hold register; a read cannot
    // tear but is a tick old at the ack.
    // No one-shot; the count restarts at 0.
    // Pins need one mclk high, one low.
    // Reading status never clears it.

    // Read mux
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            GTM_OFS_CONTROL: rd_data = {16'h0000, timer_control};
            GTM_OFS_COUNT: rd_data = {16'h0000, count_value};
            GTM_OFS_PERIOD: rd_data = {16'h0000, period_value};
            GTM_OFS_STATUS: rd_data = {14'h0000, irq_mask, 14'h0000, status};
            default: rd_data = 32'h0000_0000; // Unmapped reads zero, still acked
        endcase
    end

    // Single-cycle ack; ack drops the cycle after it was given
    always_ff @(posedge mclk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= ce && bus_req;
            if (ce && bus_req) begin
                wb_dat_o <= rd_data;
            end
        end
    end
endmodule // gtm_timer
`default_nettype wire

// [hdl/gtm_pkg.sv]
// Package: register map, field positions, reset values and cycle constants of the timer
package gtm_pkg;
    // Register byte offsets on the bus
    localparam logic [3:0] GTM_OFS_CONTROL = 4'h0;
    localparam logic [3:0] GTM_OFS_COUNT = 4'h4;
    localparam logic [3:0] GTM_OFS_PERIOD = 4'h8;
    localparam logic [3:0] GTM_OFS_STATUS = 4'hC;
    // Control register field positions
    localparam int GTM_BIT_ON = 15;
    localparam int GTM_BIT_IDLE_STOP = 13;
    localparam int GTM_BIT_GATE = 6;
    localparam int GTM_BIT_PS_HI = 5;
    localparam int GTM_BIT_PS_LO = 4;
    localparam int GTM_BIT_SYNC = 2;
    localparam int GTM_BIT_SRC = 1;
    // Writable bits of the control register
    localparam logic [15:0] GTM_CONTROL_MASK = 16'hA076;
    // Values after reset
    localparam logic [15:0] GTM_CONTROL_RST = 16'h0000;
    localparam logic [15:0] GTM_COUNT_RST = 16'h0000;
    localparam logic [15:0] GTM_PERIOD_RST = 16'hFFFF;
    // Status register: bit 0 period match, bit 1 gate falling edge
    localparam int GTM_EV_MATCH = 0;
    localparam int GTM_EV_GATE = 1;
    localparam int GTM_NUM_EV = 2;
    // Prescale codes
    typedef enum logic [1:0] {
        GTM_PS_DIV1 = 2'b00,
        GTM_PS_DIV8 = 2'b01,
        GTM_PS_DIV64 = 2'b10,
        GTM_PS_DIV256 = 2'b11
    } gtm_ps_e;
    // Prescaler terminal counts (divide minus one)
    localparam logic [7:0] GTM_TC_DIV8 = 8'h07;
    localparam logic [7:0] GTM_TC_DIV64 = 8'h3F;
    localparam logic [7:0] GTM_TC_DIV256 = 8'hFF;
endpackage

// [hdl/gtm_prescale.sv]
// Prescaler: divides qualified input ticks by 1, 8, 64 or 256
`timescale 1ns/1ps
`default_nettype none
module gtm_prescale (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic run,
    input wire logic clear,
    input wire logic tick_in,
    input wire gtm_pkg::gtm_ps_e sel,
    output logic tick_out
);
    import gtm_pkg::*;

    logic [7:0] cnt; // Prescaler count
    logic [7:0] tc; // Terminal count for the chosen ratio

    // Decode of ratio to terminal count
    always_comb begin
        unique case (sel)
            GTM_PS_DIV1: tc = 8'h00; // see (RULE17)
            GTM_PS_DIV8: tc = GTM_TC_DIV8; // see (RULE17)
            GTM_PS_DIV64: tc = GTM_TC_DIV64; // see (RULE17)
            GTM_PS_DIV256: tc = GTM_TC_DIV256; // see (RULE17)
        endcase
    end

    // Counter; only advances while running, so a timer frozen in Idle or Sleep holds it
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt <= 8'h00; // see (RULE8)
        end else if (ce && clear) begin
            cnt <= 8'h00; // see (RULE8)
        end else if (ce && run && tick_in) begin // see (RULE9)
            cnt <= (cnt >= tc) ? 8'h00 : cnt + 8'h01; // see (RULE7)
        end
    end

    // One tick out at each terminal count
    assign tick_out = run && tick_in && (cnt >= tc) && !clear; // see (RULE7)
endmodule // gtm_prescale
`default_nettype wire

// [hdl/gtm_edge.sv]
// Edge detector with optional two-stage synchroniser for the clock/gate pin
`timescale 1ns/1ps
`default_nettype none
module gtm_edge (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic pin,
    output logic sync_level,
    output logic sync_rise,
    output logic sync_fall,
    output logic raw_rise
);
    logic meta; // First stage, read only by the second
    logic sync; // Second stage
    logic sync_d; // Delayed synchronised level
    logic raw_d; // Delayed raw level

    // Pin sampling; the raw path skips the two-stage delay
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
            raw_d <= 1'b0;
        end else if (ce) begin
            meta <= pin;
            sync <= meta;
            sync_d <= sync;
            raw_d <= pin;
        end
    end

    assign sync_level = sync;
    assign sync_rise = sync && !sync_d; // see (RULE3)
    assign sync_fall = !sync && sync_d;
    assign raw_rise = pin && !raw_d; // see (RULE4)
endmodule // gtm_edge
`default_nettype wire

// [tb/gtm_pin_model.sv]
// Far-side source of the clock/gate pin: edge bursts and gate windows
`timescale 1ns/1ps
`default_nettype none
module gtm_pin_model (
    input wire logic mclk,
    output logic pin
);
    // The pin rests low between bursts, so no stray edge reaches the timer
    initial pin = 1'b0;
    // Burst of n rising edges; h cycles high, h low (h=1 is the fastest the pin may go)
    task automatic pulses(input int n, input int h);
        repeat (n) begin
            repeat (h) @(posedge mclk);
            pin <= 1'b1;
            repeat (h) @(posedge mclk);
            pin <= 1'b0;
        end
    endtask
    // Gate held high for a window of n cycles, then dropped
    task automatic gate(input int n);
        @(posedge mclk);
        pin <= 1'b1;
        repeat (n) @(posedge mclk);
        pin <= 1'b0;
    endtask
endmodule // gtm_pin_model
`default_nettype wire

// [tb/gtm_timer_sva.sv]
// Checker: bus handshake, read-back and interrupt relations at the timer ports
`timescale 1ns/1ps
`default_nettype none
module gtm_timer_sva
    import gtm_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic gate_clock_pin,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic [15:0] ctl; // Control as software last wrote it
    logic [15:0] per; // Period as software last wrote it
    logic [1:0] msk; // Interrupt mask as last written
    logic wr; // Write acknowledged in this cycle
    logic rd; // Read data presented this cycle
    assign wr = wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
    assign rd = wb_ack_o && !wb_we_i;
    // Shadows follow full-width writes only; partial lanes are not tracked
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctl <= GTM_CONTROL_RST;
            per <= GTM_PERIOD_RST;
            msk <= 2'b00;
        end else if (wr) begin
            if (wb_adr_i == GTM_OFS_CONTROL) ctl <= wb_dat_i[15:0] & GTM_CONTROL_MASK;
            if (wb_adr_i == GTM_OFS_PERIOD) per <= wb_dat_i[15:0];
            if (wb_adr_i == GTM_OFS_STATUS) msk <= wb_dat_i[17:16];
        end
    end
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_unmapped_zero: assert property (rd && wb_adr_i[1:0] != 2'b00 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_ctl_readback: assert property (rd && wb_adr_i == GTM_OFS_CONTROL |-> wb_dat_o == {16'h0000, ctl})
        else $error("control read differs from write");
    a_per_readback: assert property (rd && wb_adr_i == GTM_OFS_PERIOD |-> wb_dat_o == {16'h0000, per})
        else $error("period read differs from write");
    a_status_fields: assert property (rd && wb_adr_i == GTM_OFS_STATUS |-> wb_dat_o[31:2] == {14'h0000, msk, 14'h0000})
        else $error("status read has wrong mask or spare bits");
    a_irq_cause: assert property (irq |-> msk != 2'b00)
        else $error("irq with all events masked");
    a_irq_sticky: assert property (irq && !(wb_ack_o && wb_we_i && wb_adr_i == GTM_OFS_STATUS) |=> irq)
        else $error("irq dropped without a status write");
endmodule // gtm_timer_sva
bind gtm_timer gtm_timer_sva u_sva (.mclk(mclk), .srst(srst), .ce(ce),
    .gate_clock_pin(gate_clock_pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq));
`default_nettype wire

// [tb/testbench.sv]
// Testbench: register-level tests of the 16-bit general timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gtm_pkg::*;
    localparam logic [31:0] Z = 32'h0000_0000; // Zero data
    localparam logic [31:0] ON = 32'h0000_8000; // Enable bit
    localparam logic [31:0] SRC = 32'h0000_0002; // External source
    localparam logic [31:0] SYN = 32'h0000_0004; // Synchronised pin
    localparam logic [31:0] GT = 32'h0000_0040; // Gated accumulation
    localparam logic [31:0] IDL = 32'h0000_2000; // Stop in Idle
    logic mclk = 1'b0; // 50 MHz clock
    logic srst = 1'b1; // Held for the first 8 cycles
    logic idle = 1'b0; // CPU Idle level
    logic slp = 1'b0; // CPU Sleep level
    logic ce = 1'b1; // Clock enable
    logic [3:0] sel = 4'hF; // Byte lanes
    logic cyc = 1'b0; // Bus cycle
    logic stb = 1'b0; // Bus strobe
    logic we = 1'b0; // Bus direction
    logic [3:0] adr = 4'h0; // Bus address
    logic [31:0] wdat = 32'h0000_0000; // Bus write data
    logic [31:0] rdat; // Bus read data
    logic ack; // Bus answer
    logic irq; // Interrupt level
    logic pin; // Clock/gate pin from the model
    logic [31:0] q; // Data of the last read
    logic [31:0] q0; // Count before a frozen span
    int dv[4] = '{1, 8, 64, 256}; // Division per prescale code
    int err_total = 0;
    int cmp_count = 0;
    // Free-running clock
    always #10 mclk = ~mclk;
    // Clock enable and byte lanes are driven by the tests
    gtm_timer dut (.mclk(mclk), .srst(srst), .ce(ce), .gate_clock_pin(pin),
        .cpu_idle(idle), .cpu_sleep(slp), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq(irq));
    gtm_pin_model pm (.mclk(mclk), .pin(pin));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic cycle; holds the request until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) chk("ack", Z, 32'h0000_0001);
    endtask
    // Let cycles pass
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Counts, verdict, end of run
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard, well past the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        complete_run;
    end
    // Reset for 8 cycles
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
    end
    // Test sequence
    initial begin
        wait (srst === 1'b0);
        bus(1'b0, GTM_OFS_CONTROL, Z);
        chk("control", q, Z);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("count", q, Z);
        bus(1'b0, GTM_OFS_PERIOD, Z);
        chk("period", q, 32'h0000_FFFF);
        bus(1'b0, 4'h2, Z);
        chk("unmapped", q, Z);
        $display("reset test done");
        bus(1'b1, GTM_OFS_COUNT, 32'h0000_1234);
        bus(1'b1, GTM_OFS_CONTROL, 32'h0000_2076);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("count kept", q, 32'h0000_1234);
        sel <= 4'h1;
        bus(1'b1, GTM_OFS_COUNT, 32'h0000_FFAB);
        sel <= 4'hF;
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("count low lane", q, 32'h0000_12AB);
        $display("control write test done");
        // Each code runs about ten prescaled ticks; bus latency leaves a small spread
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, GTM_OFS_CONTROL, Z);
            bus(1'b1, GTM_OFS_COUNT, Z);
            bus(1'b1, GTM_OFS_CONTROL, ON | (32'(k) << 4));
            wt(dv[k] * 10 + dv[k] / 2 - 3);
            bus(1'b1, GTM_OFS_CONTROL, Z);
            bus(1'b0, GTM_OFS_COUNT, Z);
            chk("prescale", q >= 8 && q <= 11, 32'h0000_0001);
        end
        $display("prescale test done");
        bus(1'b1, GTM_OFS_PERIOD, 32'h0000_0004);
        bus(1'b1, GTM_OFS_COUNT, Z);
        bus(1'b1, GTM_OFS_STATUS, 32'h0001_0003);
        bus(1'b1, GTM_OFS_CONTROL, ON);
        wt(20);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("wrap", q <= 4, 32'h0000_0001);
        bus(1'b1, GTM_OFS_CONTROL, Z);
        bus(1'b0, GTM_OFS_STATUS, Z);
        chk("match flag", q, 32'h0001_0001);
        wt(5);
        chk("irq sticky", irq, 32'h0000_0001);
        bus(1'b1, GTM_OFS_STATUS, Z);
        wt(2);
        chk("irq masked", irq, Z);
        bus(1'b1, GTM_OFS_STATUS, 32'h0001_0000);
        wt(2);
        chk("irq unmasked", irq, 32'h0000_0001);
        bus(1'b1, GTM_OFS_STATUS, 32'h0001_0001);
        wt(2);
        chk("irq cleared", irq, Z);
        $display("interrupt test done");
        bus(1'b1, GTM_OFS_PERIOD, 32'h0000_FFFF);
        bus(1'b1, GTM_OFS_COUNT, Z);
        idle <= 1'b1;
        bus(1'b1, GTM_OFS_CONTROL, ON | IDL);
        wt(20);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("idle stop", q, Z);
        bus(1'b1, GTM_OFS_CONTROL, ON);
        wt(20);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("idle run", q >= 20, 32'h0000_0001);
        bus(1'b0, GTM_OFS_COUNT, Z);
        q0 = q;
        ce <= 1'b0;
        wt(30);
        ce <= 1'b1;
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("ce freeze", q, q0 + 32'h0000_0003);
        idle <= 1'b0;
        bus(1'b1, GTM_OFS_CONTROL, Z);
        bus(1'b1, GTM_OFS_COUNT, Z);
        bus(1'b1, GTM_OFS_CONTROL, ON | SRC | SYN);
        pm.pulses(5, 4);
        wt(8);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("sync count", q, 32'h0000_0005);
        slp <= 1'b1;
        pm.pulses(3, 4);
        wt(8);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("sleep sync", q, 32'h0000_0005);
        bus(1'b1, GTM_OFS_CONTROL, ON | SRC);
        pm.pulses(4, 1);
        wt(8);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("sleep async", q, 32'h0000_0009);
        idle <= 1'b1;
        bus(1'b1, GTM_OFS_CONTROL, ON | SRC | IDL);
        pm.pulses(3, 2);
        wt(8);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("idle async", q, 32'h0000_0009);
        idle <= 1'b0;
        slp <= 1'b0;
        $display("external clock test done");
        bus(1'b1, GTM_OFS_CONTROL, Z);
        bus(1'b1, GTM_OFS_COUNT, Z);
        bus(1'b1, GTM_OFS_STATUS, 32'h0002_0003);
        bus(1'b1, GTM_OFS_CONTROL, ON | GT);
        pm.gate(20);
        wt(8);
        bus(1'b0, GTM_OFS_COUNT, Z);
        chk("gated", q >= 19 && q <= 21, 32'h0000_0001);
        bus(1'b0, GTM_OFS_STATUS, Z);
        chk("gate flag", q, 32'h0002_0002);
        chk("gate irq", irq, 32'h0000_0001);
        $display("gate test done");
        complete_run;
    end
endmodule // testbench
`default_nettype wire
